/* File: core/sd_evt_core.sv */
/*
  Event flags, two-clock data buffer, card clock stop with starvation
  timer, and debounced card presence of a card host's bus-side unit.
  Assumes the card-side unit drives the event and buffer ports on
  CARD_CLOCK and that CARD_CLK_EN gates the clock sent to the card.
*/
`timescale 1ns/100ps
module sd_evt_core
(
  // clocks and reset
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CARD_CLOCK,
  // register port (host clock)
  input sd_evt_pkg::reg_req_t REG_REQ,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  output logic INT,
  // host-side status inputs
  input wire logic LOCK_ACTIVE,
  input wire logic [sd_evt_pkg::CARDS-1:0] CARD_DETECT,
  // card-side unit (card clock)
  input sd_evt_pkg::card_events_t CARD_EVENTS,
  input wire logic CARD_XFER_ACTIVE,
  input wire logic CARD_PUSH,
  input wire logic [31:0] CARD_PUSH_DATA,
  input wire logic CARD_POP,
  output logic [31:0] CARD_POP_DATA,
  output logic CARD_CLK_EN
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] tx_mem [0:255]; // host to card words
  logic [31:0] rx_mem [0:255]; // card to host words
  logic [31:0] ctrl_reg; // enable and direction
  logic [31:0] mask_reg; // interrupt mask
  logic [31:0] thresh_reg; // rx and tx thresholds
  logic [sd_evt_pkg::TOUT_W-1:0] timeout_reg; // starvation timer load, card clocks
  logic [sd_evt_pkg::TOUT_W-1:0] debounce_reg; // filter length
  logic [sd_evt_pkg::FLAG_W-1:0] raw_reg; // sticky event flags
  logic [sd_evt_pkg::FLAG_W-1:0] flag_set; // hardware sets
  logic [sd_evt_pkg::FLAG_W-1:0] flag_clr; // software clears
  logic [sd_evt_pkg::PTR_W-1:0] host_ptr_reg; // host pointer
  logic [sd_evt_pkg::PTR_W-1:0] host_gray_reg; // host pointer, gray
  logic [sd_evt_pkg::PTR_W-1:0] cg_s1_reg; // card gray, stage 1
  logic [sd_evt_pkg::PTR_W-1:0] cg_s2_reg; // card gray, stage 2
  logic [sd_evt_pkg::PTR_W-1:0] host_count; // level seen by host
  logic [sd_evt_pkg::EV_W-1:0] ev_s1_reg; // toggles, stage 1
  logic [sd_evt_pkg::EV_W-1:0] ev_s2_reg; // toggles, stage 2
  logic [sd_evt_pkg::EV_W-1:0] ev_s3_reg; // toggles, edge history
  logic [sd_evt_pkg::EV_W-1:0] ev_pulse; // one host cycle per event
  sd_evt_pkg::card_events_t ev_c; // decoded card events
  logic xa_s1_reg, xa_s2_reg; // transfer active in host domain
  logic stop_s1_reg, stop_s2_reg; // clock stopped in host domain
  logic [sd_evt_pkg::CARDS-1:0] det_s1_reg, det_s2_reg; // raw detect
  logic [sd_evt_pkg::CARDS-1:0] presence_reg; // debounced presence
  logic [sd_evt_pkg::TOUT_W-1:0] db_cnt_reg; // debounce counter
  logic cdt_pulse_reg; // presence changed
  logic lock_viol_reg, fifo_overflow_underflow_flag_reg; // host-side error events
  logic dir_wr, host_empty, host_full; // host view of the buffer
  logic wr_hit_fifo, rd_hit_fifo; // buffer accesses
  // card domain
  logic crst_s1_reg, crst_reg; // reset brought to card clock
  logic [sd_evt_pkg::PTR_W-1:0] card_ptr_reg; // card pointer
  logic [sd_evt_pkg::PTR_W-1:0] card_gray_reg; // card pointer, gray
  logic [sd_evt_pkg::PTR_W-1:0] hg_s1_reg, hg_s2_reg; // host gray sync
  logic [sd_evt_pkg::PTR_W-1:0] card_count; // level seen by card
  logic dir_s1_reg, dir_s2_reg; // direction in card domain
  logic [sd_evt_pkg::TOUT_W-1:0] to_s1_reg, to_s2_reg; // timeout copy
  logic [sd_evt_pkg::TOUT_W-1:0] starve_cnt_reg; // starvation timer
  logic [sd_evt_pkg::EV_W-1:0] ev_tgl_reg; // event toggles
  logic stall, stall_reg, hto_fire; // clock stop state

  ////////////////////////////////////////////////////////////////////////
  // host view of the buffer level
  assign dir_wr = ctrl_reg[sd_evt_pkg::CTRL_DIR_WR];
  always_comb
  begin
    if (dir_wr)
      host_count = host_ptr_reg - sd_evt_pkg::gray2bin(cg_s2_reg);
    else
      host_count = sd_evt_pkg::gray2bin(cg_s2_reg) - host_ptr_reg;
  end
  assign host_empty = (host_count == 9'h000);
  assign host_full = (host_count == sd_evt_pkg::FIFO_DEPTH);
  assign wr_hit_fifo = REG_REQ.wr && (REG_REQ.addr == sd_evt_pkg::OFF_FIFO);
  assign rd_hit_fifo = REG_REQ.rd && (REG_REQ.addr == sd_evt_pkg::OFF_FIFO);

  // card pointer and status into the host clock
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      cg_s1_reg <= 9'h000;
      cg_s2_reg <= 9'h000;
      xa_s1_reg <= 1'h0;
      xa_s2_reg <= 1'h0;
      stop_s1_reg <= 1'h0;
      stop_s2_reg <= 1'h0;
    end
    else
    begin
      cg_s1_reg <= card_gray_reg;
      cg_s2_reg <= cg_s1_reg;
      xa_s1_reg <= CARD_XFER_ACTIVE;
      xa_s2_reg <= xa_s1_reg;
      stop_s1_reg <= ~CARD_CLK_EN;
      stop_s2_reg <= stop_s1_reg;
    end
  end

  // card events arrive as toggles and leave as pulses
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ev_s1_reg <= 12'h000;
      ev_s2_reg <= 12'h000;
      ev_s3_reg <= 12'h000;
    end
    else
    begin
      ev_s1_reg <= ev_tgl_reg;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
    end
  end
  assign ev_pulse = ev_s2_reg ^ ev_s3_reg;
  assign ev_c = ev_pulse[10:0];

  ////////////////////////////////////////////////////////////////////////
  // host port of both buffers; a refused access only raises the flag
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      host_ptr_reg <= 9'h000;
      host_gray_reg <= 9'h000;
      fifo_overflow_underflow_flag_reg <= 1'h0;
    end
    else
    begin
      fifo_overflow_underflow_flag_reg <= 1'h0;
      // push while writing to the card
      if (wr_hit_fifo && dir_wr)
      begin
        if (host_full)
          fifo_overflow_underflow_flag_reg <= 1'h1;
        else
        begin
          tx_mem[host_ptr_reg[7:0]] <= REG_REQ.wdata;
          host_ptr_reg <= host_ptr_reg + 9'h001;
          host_gray_reg <= sd_evt_pkg::bin2gray(host_ptr_reg + 9'h001);
        end
      end
      // pop while reading from the card
      else if (rd_hit_fifo && !dir_wr)
      begin
        if (host_empty)
          fifo_overflow_underflow_flag_reg <= 1'h1;
        else
        begin
          host_ptr_reg <= host_ptr_reg + 9'h001;
          host_gray_reg <= sd_evt_pkg::bin2gray(host_ptr_reg + 9'h001);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; the timeout is locked during command hand-over
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ctrl_reg <= sd_evt_pkg::CTRL_RST;
      mask_reg <= sd_evt_pkg::MASK_RST;
      thresh_reg <= sd_evt_pkg::THRESH_RST;
      timeout_reg <= sd_evt_pkg::TIMEOUT_RST;
      debounce_reg <= sd_evt_pkg::DEBOUNCE_RST;
      lock_viol_reg <= 1'h0;
    end
    else
    begin
      lock_viol_reg <= 1'h0;
      if (REG_REQ.wr)
      begin
        case (REG_REQ.addr)
          sd_evt_pkg::OFF_CTRL: ctrl_reg <= REG_REQ.wdata & 32'h00000003;
          sd_evt_pkg::OFF_MASK: mask_reg <= REG_REQ.wdata;
          sd_evt_pkg::OFF_THRESH: thresh_reg <= REG_REQ.wdata & 32'h01FF01FF;
          sd_evt_pkg::OFF_DEBOUNCE: debounce_reg <= REG_REQ.wdata[23:0];
          sd_evt_pkg::OFF_TIMEOUT:
          begin
            // write ignored while locked
            if (LOCK_ACTIVE)
              lock_viol_reg <= 1'h1;
            else
              timeout_reg <= REG_REQ.wdata[23:0];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // card detect: two-flop sync, then debounce filter
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      det_s1_reg <= 4'h0;
      det_s2_reg <= 4'h0;
      presence_reg <= 4'h0;
      db_cnt_reg <= 24'h000000;
      cdt_pulse_reg <= 1'h0;
    end
    else
    begin
      det_s1_reg <= CARD_DETECT;
      det_s2_reg <= det_s1_reg;
      cdt_pulse_reg <= 1'h0;
      // stable: restart the filter
      if (det_s2_reg == presence_reg)
        db_cnt_reg <= 24'h000000;
      // held long enough: accept all changed cards at once
      else if (db_cnt_reg >= debounce_reg)
      begin
        presence_reg <= det_s2_reg;
        db_cnt_reg <= 24'h000000;
        cdt_pulse_reg <= 1'h1;
      end
      else
        db_cnt_reg <= db_cnt_reg + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // which flags hardware sets this cycle
  always_comb
  begin
    flag_set = '0;
    flag_set[16] = ev_c.busy_end;
    flag_set[15] = ev_c.end_bit_fault;
    flag_set[14] = ev_c.auto_stop_done;
    flag_set[13] = ev_c.start_bit_fault;
    flag_set[12] = lock_viol_reg;
    flag_set[11] = fifo_overflow_underflow_flag_reg;
    flag_set[10] = ev_pulse[11];
    flag_set[9] = ev_c.data_timeout;
    // no data phase follows is the card side's duty
    flag_set[8] = ev_c.reply_timeout;
    flag_set[7] = ev_c.data_crc;
    flag_set[6] = ev_c.resp_crc;
    flag_set[5] = xa_s2_reg && !dir_wr
      && (host_count > thresh_reg[sd_evt_pkg::RX_LSB +: 9]);
    flag_set[4] = xa_s2_reg && dir_wr
      && (host_count <= thresh_reg[sd_evt_pkg::TX_LSB +: 9]);
    flag_set[3] = ev_c.xfer_over || ev_c.data_timeout;
    flag_set[2] = ev_c.cmd_done || ev_c.reply_timeout;
    flag_set[1] = ev_c.answer_fault;
    flag_set[0] = cdt_pulse_reg;
  end

  // write one to clear; a set in the same cycle wins
  assign flag_clr = (REG_REQ.wr && REG_REQ.addr == sd_evt_pkg::OFF_RAW)
    ? REG_REQ.wdata[16:0] : 17'h00000;
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      raw_reg <= 17'h00000;
    else
      raw_reg <= (raw_reg & ~flag_clr) | flag_set;
  end

  // registered level interrupt
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      INT <= 1'h0;
    else
      INT <= (|(raw_reg & mask_reg[16:0]))
        && ctrl_reg[sd_evt_pkg::CTRL_INT_EN];
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      REG_RDATA <= 32'h00000000;
      REG_RVALID <= 1'h0;
    end
    else
    begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd)
      begin
        case (REG_REQ.addr)
          sd_evt_pkg::OFF_CTRL: REG_RDATA <= ctrl_reg;
          sd_evt_pkg::OFF_MASK: REG_RDATA <= mask_reg;
          sd_evt_pkg::OFF_THRESH: REG_RDATA <= thresh_reg;
          sd_evt_pkg::OFF_TIMEOUT: REG_RDATA <= {8'h00, timeout_reg};
          sd_evt_pkg::OFF_DEBOUNCE: REG_RDATA <= {8'h00, debounce_reg};
          sd_evt_pkg::OFF_RAW: REG_RDATA <= {15'h0000, raw_reg};
          sd_evt_pkg::OFF_PRESENCE:
            REG_RDATA <= {28'h0000000, presence_reg};
          sd_evt_pkg::OFF_STATUS:
            REG_RDATA <= {20'h00000, stop_s2_reg, host_empty, host_full,
              host_count};
          sd_evt_pkg::OFF_FIFO:
          begin
            // synchronous read of the receive memory
            if (!dir_wr && !host_empty)
              REG_RDATA <= rx_mem[host_ptr_reg[7:0]];
            else
              REG_RDATA <= 32'h00000000;
          end
          default: REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // card clock: reset and quasi-static settings brought across;
  // timeout writes are refused while LOCK_ACTIVE is high; direction can change at any time
  always_ff @(posedge CARD_CLOCK)
  begin
    crst_s1_reg <= RST;
    crst_reg <= crst_s1_reg;
    dir_s1_reg <= dir_wr;
    dir_s2_reg <= dir_s1_reg;
    to_s1_reg <= timeout_reg;
    to_s2_reg <= to_s1_reg;
    hg_s1_reg <= host_gray_reg;
    hg_s2_reg <= hg_s1_reg;
  end

  // card view of the buffer level
  always_comb
  begin
    if (dir_s2_reg)
      card_count = sd_evt_pkg::gray2bin(hg_s2_reg) - card_ptr_reg;
    else
      card_count = card_ptr_reg - sd_evt_pkg::gray2bin(hg_s2_reg);
  end
  // empty on write or full on read starves the card
  assign stall = CARD_XFER_ACTIVE && (dir_s2_reg
    ? (card_count == 9'h000) : (card_count == sd_evt_pkg::FIFO_DEPTH));

  // card port of both buffers
  always_ff @(posedge CARD_CLOCK)
  begin
    if (crst_reg)
    begin
      card_ptr_reg <= 9'h000;
      card_gray_reg <= 9'h000;
      CARD_POP_DATA <= 32'h00000000;
    end
    else if (CARD_PUSH && !dir_s2_reg)
    begin
      rx_mem[card_ptr_reg[7:0]] <= CARD_PUSH_DATA;
      card_ptr_reg <= card_ptr_reg + 9'h001;
      card_gray_reg <= sd_evt_pkg::bin2gray(card_ptr_reg + 9'h001);
    end
    else if (CARD_POP && dir_s2_reg)
    begin
      CARD_POP_DATA <= tx_mem[card_ptr_reg[7:0]];
      card_ptr_reg <= card_ptr_reg + 9'h001;
      card_gray_reg <= sd_evt_pkg::bin2gray(card_ptr_reg + 9'h001);
    end
  end

  // clock stop and starvation timer
  assign hto_fire = stall && stall_reg && (starve_cnt_reg == 24'h000001);
  always_ff @(posedge CARD_CLOCK)
  begin
    if (crst_reg)
    begin
      stall_reg <= 1'h0;
      CARD_CLK_EN <= 1'h1;
      starve_cnt_reg <= 24'h000000;
    end
    else
    begin
      stall_reg <= stall;
      CARD_CLK_EN <= !stall;
      if (stall && !stall_reg)
        starve_cnt_reg <= to_s2_reg;
      else if (stall && starve_cnt_reg != 24'h000000)
        starve_cnt_reg <= starve_cnt_reg - 24'h000001;
    end
  end

  // each card event flips its toggle
  always_ff @(posedge CARD_CLOCK)
  begin
    if (crst_reg)
      ev_tgl_reg <= 12'h000;
    else
      ev_tgl_reg <= ev_tgl_reg ^ {hto_fire, CARD_EVENTS};
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_W1C_HOLD:
  assert property (@(posedge CLOCK) disable iff (RST)
    !(REG_REQ.wr && REG_REQ.addr == sd_evt_pkg::OFF_RAW)
    |=> ((raw_reg & $past(raw_reg)) == $past(raw_reg)))
    else $error("flag dropped without a clearing write");

  AST_INT_GATE:
  assert property (@(posedge CLOCK) disable iff (RST)
    INT == $past((|(raw_reg & mask_reg[16:0])) && ctrl_reg[0]))
    else $error("interrupt does not follow flags, mask and enable");

  AST_RTO_CD:
  assert property (@(posedge CLOCK) disable iff (RST)
    ev_c.reply_timeout |=> raw_reg[8] && raw_reg[2])
    else $error("reply timeout did not raise both flags");

  AST_READ_DATA_TIMEOUT_FLAG_DTO:
  assert property (@(posedge CLOCK) disable iff (RST)
    ev_c.data_timeout |=> raw_reg[9] && raw_reg[3])
    else $error("data timeout did not raise both flags");

  AST_LOCK:
  assert property (@(posedge CLOCK) disable iff (RST)
    REG_REQ.wr && REG_REQ.addr == sd_evt_pkg::OFF_TIMEOUT && LOCK_ACTIVE
    |=> ##1 raw_reg[12] && $stable(timeout_reg))
    else $error("locked write not refused and flagged");

  AST_FIFO_OVERFLOW_UNDERFLOW_FLAG:
  assert property (@(posedge CLOCK) disable iff (RST)
    rd_hit_fifo && !dir_wr && host_empty
    |=> ##1 raw_reg[11])
    else $error("pop from empty buffer not flagged");

  AST_CLK_STOP:
  assert property (@(posedge CARD_CLOCK) disable iff (crst_reg)
    stall && !stall_reg |=> !CARD_CLK_EN && starve_cnt_reg == $past(to_s2_reg))
    else $error("starvation did not stop clock and load timer");

  AST_PRESENCE:
  assert property (@(posedge CLOCK) disable iff (RST)
    $changed(presence_reg) |-> ##1 raw_reg[0])
    else $error("presence change did not set its flag");

  AST_TRANSMIT_FIFO_REQUEST_FLAG:
  assert property (@(posedge CLOCK) disable iff (RST)
    xa_s2_reg && dir_wr && host_count <= thresh_reg[8:0] |=> raw_reg[4])
    else $error("transmit request flag missing");

endmodule

/* File: core/sd_evt_pkg.sv */
/*
  Shared constants, carrier types and pointer helpers for the card host
  event, data-buffer and card-presence block.
  Assumes a 32-bit register port on the host clock and a card-side unit
  running on its own card clock.
*/
package sd_evt_pkg;

  // data and buffer geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int FIFO_AW = 8;
  localparam int PTR_W = FIFO_AW + 1;
  localparam logic [PTR_W-1:0] FIFO_DEPTH = 9'h100;
  localparam int CARDS = 4;
  localparam int TOUT_W = 24;
  localparam int FLAG_W = 17;
  localparam int TH_W = 9;
  localparam int EV_W = 12;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_RAW = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_THRESH = 12'h04C;
  localparam logic [ADDR_W-1:0] OFF_PRESENCE = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_DEBOUNCE = 12'h064;
  localparam logic [ADDR_W-1:0] OFF_FIFO = 12'h100;

  // field positions
  localparam int CTRL_INT_EN = 0;
  localparam int CTRL_DIR_WR = 1;
  localparam int TX_LSB = 0;
  localparam int RX_LSB = 16;
  localparam int ST_STOP = 11;
  localparam int ST_EMPTY = 10;
  localparam int ST_FULL = 9;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] MASK_RST = 32'h00000000;
  localparam logic [TOUT_W-1:0] TIMEOUT_RST = 24'hFFFFFF;
  localparam logic [DATA_W-1:0] THRESH_RST = 32'h007F0080;
  localparam logic [TOUT_W-1:0] DEBOUNCE_RST = 24'h0FFFFF;

  // one-cycle events from the card-side unit (card clock)
  typedef struct packed {
    logic busy_end;
    logic end_bit_fault;
    logic auto_stop_done;
    logic start_bit_fault;
    logic data_timeout;
    logic reply_timeout;
    logic data_crc;
    logic resp_crc;
    logic xfer_over;
    logic cmd_done;
    logic answer_fault;
  } card_events_t;

  // one register request (host clock)
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // binary to gray
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // gray to binary
  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

/* File: dv/card_side_model.sv */
/*
  stand-in for the card-side unit: event pulses, buffer push and pop
  on the card clock.
  assumes the bench makes the card clock and calls the tasks below.
*/
`timescale 1ns/100ps
module card_side_model
(
  // card clock and bench request
  input wire logic CARD_CLOCK,
  input wire logic XFER,
  // toward the design
  output sd_evt_pkg::card_events_t CARD_EVENTS,
  output logic CARD_XFER_ACTIVE,
  output logic CARD_PUSH,
  output logic [31:0] CARD_PUSH_DATA,
  output logic CARD_POP,
  // from the design
  input wire logic [31:0] CARD_POP_DATA,
  input wire logic CARD_CLK_EN
);
  // idle levels at time zero
  initial
  begin
    CARD_EVENTS = '0;
    CARD_XFER_ACTIVE = 1'b0;
    CARD_PUSH = 1'b0;
    CARD_PUSH_DATA = 32'h0;
    CARD_POP = 1'b0;
  end
  ////////////////////////////////////////
  // transfer level follows the bench
  always @(posedge CARD_CLOCK)
    CARD_XFER_ACTIVE <= XFER;
  // a card does nothing while its clock is held
  task automatic hold_off;
    for (int n = 0; n < 200 && CARD_CLK_EN !== 1'b1; n++)
      @(posedge CARD_CLOCK);
  endtask
  // one-cycle event pulse
  task automatic fire(input sd_evt_pkg::card_events_t e);
    @(posedge CARD_CLOCK) CARD_EVENTS <= e;
    @(posedge CARD_CLOCK) CARD_EVENTS <= '0;
  endtask
  // one word into the buffer; data line scrambled afterwards
  task automatic push(input logic [31:0] d);
    hold_off();
    @(posedge CARD_CLOCK) CARD_PUSH <= 1'b1;
    CARD_PUSH_DATA <= d;
    @(posedge CARD_CLOCK) CARD_PUSH <= 1'b0;
    CARD_PUSH_DATA <= ~d;
  endtask
  // one word out of the buffer, taken the cycle after the pop
  task automatic pop(output logic [31:0] d);
    hold_off();
    @(posedge CARD_CLOCK) CARD_POP <= 1'b1;
    @(posedge CARD_CLOCK) CARD_POP <= 1'b0;
    #1 d = CARD_POP_DATA;
  endtask
endmodule

/* File: dv/testbench.sv */
/*
  bench for the event, buffer and presence block through its register
  port and a card-side stand-in.
  assumes the package, core and stand-in are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  // bench signals
  logic clock, card_clock, rst, lock, xfer, int_out, rvalid, clken;
  logic push, pop, xact;
  logic [3:0] detect;
  logic [31:0] rdata, pdata, popdata, word;
  sd_evt_pkg::reg_req_t req;
  sd_evt_pkg::card_events_t events;
  int mismatches, checks;
  // raw flags expected for each card event bit, lsb first
  logic [31:0] evexp [11] = '{32'h2, 32'h4, 32'h8, 32'h40, 32'h80,
    32'h104, 32'h208, 32'h2000, 32'h4000, 32'h8000, 32'h10000};
  ////////////////////////////////////////
  // two unrelated clocks
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    card_clock = 1'b0;
    #3;
    forever #7.5 card_clock = ~card_clock;
  end
  sd_evt_core sd_evt_core_inst
  (
    .CLOCK(clock), .RST(rst), .CARD_CLOCK(card_clock),
    .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .INT(int_out), .LOCK_ACTIVE(lock), .CARD_DETECT(detect),
    .CARD_EVENTS(events), .CARD_XFER_ACTIVE(xact), .CARD_PUSH(push),
    .CARD_PUSH_DATA(pdata), .CARD_POP(pop), .CARD_POP_DATA(popdata),
    .CARD_CLK_EN(clken)
  );
  card_side_model card_side_model_inst
  (
    .CARD_CLOCK(card_clock), .XFER(xfer), .CARD_EVENTS(events),
    .CARD_XFER_ACTIVE(xact), .CARD_PUSH(push), .CARD_PUSH_DATA(pdata),
    .CARD_POP(pop), .CARD_POP_DATA(popdata), .CARD_CLK_EN(clken)
  );
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // register write, one cycle request
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock) req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) req <= '0;
  endtask
  // register read with its answer checked against a value;
  // valid stands only in the cycle after the strobe is taken
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock) req <= '0;
    #1 chk("read valid", {31'h0, rvalid}, 32'h1);
    chk($sformatf("register %h", a), rdata, e);
    @(posedge clock);
  endtask
  // verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(50 * 20000);
    mismatches++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    lock = 1'b0;
    xfer = 1'b0;
    detect = 4'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    rdc(sd_evt_pkg::OFF_RAW, 32'h0);
    rdc(sd_evt_pkg::OFF_THRESH, sd_evt_pkg::THRESH_RST);
    rdc(12'h0F0, 32'h0);
    // each card event sets its flags; zero keeps them, one clears
    for (int i = 0; i < 11; i++)
    begin
      card_side_model_inst.fire(11'h1 << i);
      repeat (8) @(posedge clock);
      rdc(sd_evt_pkg::OFF_RAW, evexp[i]);
      wr(sd_evt_pkg::OFF_RAW, 32'h0);
      rdc(sd_evt_pkg::OFF_RAW, evexp[i]);
      wr(sd_evt_pkg::OFF_RAW, 32'hFFFFFFFF);
      rdc(sd_evt_pkg::OFF_RAW, 32'h0);
    end
    // card read data crosses, then host pops the empty buffer
    card_side_model_inst.push(32'hA5C30F96);
    repeat (10) @(posedge clock);
    rdc(sd_evt_pkg::OFF_FIFO, 32'hA5C30F96);
    rdc(sd_evt_pkg::OFF_FIFO, 32'h0);
    rdc(sd_evt_pkg::OFF_RAW, 32'h800);
    wr(sd_evt_pkg::OFF_RAW, 32'hFFFFFFFF);
    // starved write: clock stops, timer expires, host push restarts
    wr(sd_evt_pkg::OFF_TIMEOUT, 32'h4);
    wr(sd_evt_pkg::OFF_CTRL, 32'h2);
    xfer <= 1'b1;
    repeat (30) @(posedge clock);
    chk("card clock enable", {31'h0, clken}, 32'h0);
    rdc(sd_evt_pkg::OFF_RAW, 32'h410);
    wr(sd_evt_pkg::OFF_FIFO, 32'h11223344);
    repeat (10) @(posedge clock);
    chk("card clock enable", {31'h0, clken}, 32'h1);
    card_side_model_inst.pop(word);
    chk("card pop data", word, 32'h11223344);
    xfer <= 1'b0;
    wr(sd_evt_pkg::OFF_CTRL, 32'h0);
    repeat (20) @(posedge clock);
    wr(sd_evt_pkg::OFF_RAW, 32'hFFFFFFFF);
    // locked timeout write is dropped and flagged
    lock <= 1'b1;
    wr(sd_evt_pkg::OFF_TIMEOUT, 32'h9);
    lock <= 1'b0;
    rdc(sd_evt_pkg::OFF_RAW, 32'h1000);
    rdc(sd_evt_pkg::OFF_TIMEOUT, 32'h4);
    wr(sd_evt_pkg::OFF_RAW, 32'hFFFFFFFF);
    // short detect glitch is filtered, two cards together give one event
    wr(sd_evt_pkg::OFF_DEBOUNCE, 32'h4);
    detect <= 4'h5;
    repeat (2) @(posedge clock);
    detect <= 4'h0;
    repeat (20) @(posedge clock);
    rdc(sd_evt_pkg::OFF_RAW, 32'h0);
    detect <= 4'h5;
    repeat (20) @(posedge clock);
    rdc(sd_evt_pkg::OFF_PRESENCE, 32'h5);
    rdc(sd_evt_pkg::OFF_RAW, 32'h1);
    // interrupt needs flag, mask and enable
    wr(sd_evt_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    chk("interrupt", {31'h0, int_out}, 32'h0);
    wr(sd_evt_pkg::OFF_MASK, 32'h1);
    repeat (3) @(posedge clock);
    chk("interrupt", {31'h0, int_out}, 32'h1);
    wr(sd_evt_pkg::OFF_RAW, 32'h1);
    repeat (3) @(posedge clock);
    chk("interrupt", {31'h0, int_out}, 32'h0);
    // card read fills the buffer: clock stops, the first of two host pops restarts it
    xfer <= 1'b1;
    for (int i = 0; i < 256; i++)
      card_side_model_inst.push(32'hC0DE0000 + i);
    repeat (30) @(posedge clock);
    chk("card clock enable", {31'h0, clken}, 32'h0);
    rdc(sd_evt_pkg::OFF_RAW, 32'h420);
    rdc(sd_evt_pkg::OFF_FIFO, 32'hC0DE0000);
    rdc(sd_evt_pkg::OFF_FIFO, 32'hC0DE0001);
    repeat (10) @(posedge clock);
    chk("card clock enable", {31'h0, clken}, 32'h1);
    // no card reset is sent mid-transfer; the transfer level just drops
    xfer <= 1'b0;
    give_verdict();
  end
endmodule
